/* File: hw/crsw_route_select.sv */
// Control decode and routing fabric for a four-source crosspoint switch.
// Assumes the serial control port has been decoded into register read and write
// strobes on core_clk, and that channel and side lines are asynchronous levels.
// Channel and line index is source times four plus channel, A0 first and D3 last.
`timescale 1ns/100ps
`include "crsw_defs.svh"

module crsw_route_select
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Register access
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wr_data,
  output logic [7:0] reg_rd_data,
  // Fast channels
  input wire logic [15:0] fast_in,
  output logic [3:0] fast_out,
  output logic fast_standby,
  // Side lines
  input wire logic [15:0] side_in,
  output logic [3:0] side_common_lines,
  output logic [3:0] side_common_oe_n
);

  // ==========================================
  // Reset release
  logic [1:0] rst_sync_q;
  logic rst_n;

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      rst_sync_q <= 2'h0;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end

  assign rst_n = rst_sync_q[1];

  // ==========================================
  // Functions

  // A write carrying the illegal bundling code leaves the held mode alone.
  function automatic crsw_pkg::crsw_bundle_type next_mode(input logic [1:0] wr_mode,
                                                         input crsw_pkg::crsw_bundle_type old);
    if (wr_mode == `CRSW_ILLEGAL_MODE)
      next_mode = old;
    else
      next_mode = crsw_pkg::crsw_bundle_type'(wr_mode);
  endfunction

  function automatic logic [7:0] pack_reg(input logic on, input crsw_pkg::crsw_bundle_type mode,
                                          input logic [3:0] pick);
    pack_reg = {1'b0, on, mode, pick};
  endfunction

  // Quad and single decodes serve both fabrics; only the dual pairing differs.
  function automatic logic [3:0] quad_route(input logic [15:0] lines, input logic [1:0] src);
    quad_route = lines[{src, 2'h0} +: 4];
  endfunction

  function automatic logic [3:0] single_route(input logic [15:0] lines, input logic [3:0] pick);
    single_route = {4{lines[pick]}};
  endfunction

  // Each picked channel drives both lines of its output pair, so a receiver wired
  // to either line of the pair sees it.
  function automatic logic [3:0] fast_dual_route(input logic [15:0] lines,
                                                 input logic [2:0] pair);
    fast_dual_route = {{2{lines[{pair, 1'b1}]}}, {2{lines[{pair, 1'b0}]}}};
  endfunction

  // Side pairs join source A with C and B with D; A or B takes the low common pair.
  function automatic logic [3:0] side_dual_route(input logic [15:0] lines,
                                                 input logic [2:0] pair);
    side_dual_route = {{2{lines[{1'b1, pair}]}}, {2{lines[{1'b0, pair}]}}};
  endfunction

  // ==========================================
  // Control registers
  logic fast_path_on_q;
  crsw_pkg::crsw_bundle_type fast_bundling_mode_q;
  logic [3:0] fast_source_pick_q;
  logic side_path_on_q;
  crsw_pkg::crsw_bundle_type side_bundling_mode_q;
  logic [3:0] side_source_pick_q;
  logic fast_wr;
  logic side_wr;
  // Reset fields are cut from the register reset words, so both stay in step.
  localparam logic [7:0] fast_rst_val = `CRSW_FAST_ROUTE_CONTROL_RST;
  localparam logic [7:0] side_rst_val = `CRSW_SIDE_ROUTE_CONTROL_RST;

  assign fast_wr = reg_wr_en && (reg_addr == `CRSW_FAST_ROUTE_CONTROL_OFS);
  assign side_wr = reg_wr_en && (reg_addr == `CRSW_SIDE_ROUTE_CONTROL_OFS);

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      fast_path_on_q <= fast_rst_val[`CRSW_ON_BIT];
    else if (fast_wr)
      fast_path_on_q <= reg_wr_data[`CRSW_ON_BIT];
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      fast_bundling_mode_q <=
        crsw_pkg::crsw_bundle_type'(fast_rst_val[`CRSW_MODE_HI:`CRSW_MODE_LO]);
    else if (fast_wr)
      fast_bundling_mode_q <= next_mode(reg_wr_data[`CRSW_MODE_HI:`CRSW_MODE_LO],
                                        fast_bundling_mode_q);
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      fast_source_pick_q <= fast_rst_val[`CRSW_PICK_HI:`CRSW_PICK_LO];
    else if (fast_wr)
      fast_source_pick_q <= reg_wr_data[`CRSW_PICK_HI:`CRSW_PICK_LO];
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      side_path_on_q <= side_rst_val[`CRSW_ON_BIT];
    else if (side_wr)
      side_path_on_q <= reg_wr_data[`CRSW_ON_BIT];
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      side_bundling_mode_q <=
        crsw_pkg::crsw_bundle_type'(side_rst_val[`CRSW_MODE_HI:`CRSW_MODE_LO]);
    else if (side_wr)
      side_bundling_mode_q <= next_mode(reg_wr_data[`CRSW_MODE_HI:`CRSW_MODE_LO],
                                        side_bundling_mode_q);
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      side_source_pick_q <= side_rst_val[`CRSW_PICK_HI:`CRSW_PICK_LO];
    else if (side_wr)
      side_source_pick_q <= reg_wr_data[`CRSW_PICK_HI:`CRSW_PICK_LO];
  end

  // ==========================================
  // Register read-back
  // Unmapped addresses read as zero so software sees a defined value.
  // A read and a write of one register in the same cycle return the old value.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rd_data <= 8'h00;
    else if (reg_rd_en)
    begin
      case (reg_addr)
        `CRSW_FAST_ROUTE_CONTROL_OFS:
          reg_rd_data <= pack_reg(fast_path_on_q, fast_bundling_mode_q, fast_source_pick_q);
        `CRSW_SIDE_ROUTE_CONTROL_OFS:
          reg_rd_data <= pack_reg(side_path_on_q, side_bundling_mode_q, side_source_pick_q);
        default:
          reg_rd_data <= 8'h00;
      endcase
    end
  end

  // ==========================================
  // Input synchronisers
  // Three stages with an agreement filter: the first stage may be metastable and
  // is read only by the second, so a change counts once stages two and three match.
  logic [31:0] pin_s1_q;
  logic [31:0] pin_s2_q;
  logic [31:0] pin_s3_q;
  logic [31:0] pin_clean_q;
  logic [15:0] fast_clean;
  logic [15:0] side_clean;

  genvar gi;
  generate
    for (gi = 0; gi < 32; gi = gi + 1)
    begin : g_sync
      always_ff @(posedge core_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          pin_s1_q[gi] <= 1'b0;
          pin_s2_q[gi] <= 1'b0;
          pin_s3_q[gi] <= 1'b0;
        end
        else
        begin
          pin_s1_q[gi] <= (gi < 16) ? fast_in[gi % 16] : side_in[gi % 16];
          pin_s2_q[gi] <= pin_s1_q[gi];
          pin_s3_q[gi] <= pin_s2_q[gi];
        end
      end

      // Stages that disagree hold the old level, so pulses under two cycles may vanish.
      always_ff @(posedge core_clk or negedge rst_n)
      begin
        if (!rst_n)
          pin_clean_q[gi] <= 1'b0;
        else if (pin_s2_q[gi] == pin_s3_q[gi])
          pin_clean_q[gi] <= pin_s3_q[gi];
      end
    end
  endgenerate

  assign fast_clean = pin_clean_q[15:0];
  assign side_clean = pin_clean_q[31:16];

  // ==========================================
  // Fast fabric
  // Pick bits unused in quad and dual mode are kept and read back, not cleared.
  logic [3:0] fast_route;

  always_comb
  begin
    fast_route = 4'h0;
    case (fast_bundling_mode_q)
      crsw_pkg::crsw_quad:
        fast_route = quad_route(fast_clean, fast_source_pick_q[1:0]);
      // even to lower pair, odd to upper
      crsw_pkg::crsw_dual:
        fast_route = fast_dual_route(fast_clean, fast_source_pick_q[2:0]);
      crsw_pkg::crsw_single:
        fast_route = single_route(fast_clean, fast_source_pick_q);
      default:
        fast_route = 4'h0;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      fast_out <= 4'h0;
    else
      fast_out <= fast_path_on_q ? fast_route : 4'h0;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      fast_standby <= 1'b0;
    else
      fast_standby <= !fast_path_on_q;
  end

  // ==========================================
  // Side fabric
  // Side lines are modelled one way only, from the source lines to the common lines.
  logic [3:0] side_route;

  always_comb
  begin
    side_route = 4'h0;
    case (side_bundling_mode_q)
      crsw_pkg::crsw_quad:
        side_route = quad_route(side_clean, side_source_pick_q[1:0]);
      // A/B low pair, C/D high pair
      crsw_pkg::crsw_dual:
        side_route = side_dual_route(side_clean, side_source_pick_q[2:0]);
      crsw_pkg::crsw_single:
        side_route = single_route(side_clean, side_source_pick_q);
      default:
        side_route = 4'h0;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      side_common_lines <= 4'h0;
    else
      side_common_lines <= side_path_on_q ? side_route : 4'h0;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      side_common_oe_n <= 4'hf;
    else
      side_common_oe_n <= side_path_on_q ? 4'h0 : 4'hf;
  end

endmodule // crsw_route_select

/* File: hw/crsw_defs.svh */
// Offsets, field positions, reset values and the illegal mode code for the crosspoint route decode.
// Assumes inclusion by bare name in the design file; definitions only.
//
// Operation
// - Fast enable low means standby, outputs off.
// - Fast bundling picks quad, dual or single.
// - Fast bundling code 11 ignored, old kept.
// - Fast quad: low two bits pick source.
// - Fast dual: three bits pick channel pair.
// - Fast single: four bits pick one channel.
// - Side enable low connects no side line.
// - Side bundling picks quad, dual or single.
// - Side bundling code 11 ignored, old kept.
// - Side quad: low two bits pick source.
// - Side dual: A/C or B/D line pairs.
// - Side single: four bits pick one line.
`ifndef CRSW_DEFS_SVH
`define CRSW_DEFS_SVH

// ==========================================
// Register map
`define CRSW_FAST_ROUTE_CONTROL_OFS 8'h00
`define CRSW_SIDE_ROUTE_CONTROL_OFS 8'h01
`define CRSW_FAST_ROUTE_CONTROL_RST 8'h40
`define CRSW_SIDE_ROUTE_CONTROL_RST 8'h40

// ==========================================
// Field layout, shared by both control registers
`define CRSW_ON_BIT 6
`define CRSW_MODE_HI 5
`define CRSW_MODE_LO 4
`define CRSW_PICK_HI 3
`define CRSW_PICK_LO 0
`define CRSW_ILLEGAL_MODE 2'h3

`endif

/* File: hw/crsw_pkg.sv */
// Types shared by the crosspoint route decode.
// Assumes nothing beyond a SystemVerilog compiler.
package crsw_pkg;

  typedef enum logic [1:0] {
    crsw_quad = 2'h0,
    crsw_dual = 2'h1,
    crsw_single = 2'h2
  } crsw_bundle_type;

endpackage

/* File: verification/crsw_route_monitor.sv */
// Port checker for the route decode.
// Assumes outputs follow a register write two edges later.
`timescale 1ns/100ps
module crsw_route_monitor
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Register access
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wr_data,
  // Outputs
  input wire logic [3:0] fast_out,
  input wire logic fast_standby,
  input wire logic [3:0] side_common_lines,
  input wire logic [3:0] side_common_oe_n
);
  default clocking dc @(posedge core_clk);
  endclocking
  default disable iff (!rstn);
  logic fw, sw;
  assign fw = reg_wr_en && reg_addr == 8'h00;
  assign sw = reg_wr_en && reg_addr == 8'h01;
  // ==========================================
  // Enables
  a_standby_quiet: assert property (fast_standby |-> fast_out == 4'h0)
    else $error("fast output live in standby");
  a_fast_off: assert property (fw && !reg_wr_data[6] |-> ##2 fast_standby)
    else $error("fast path still on");
  a_fast_on: assert property (fw && reg_wr_data[6] |-> ##2 !fast_standby)
    else $error("fast path still off");
  a_side_idle: assert property (side_common_oe_n == 4'hf |-> side_common_lines == 4'h0)
    else $error("side lines live while off");
  a_side_off: assert property (sw && !reg_wr_data[6] |-> ##2 side_common_oe_n == 4'hf)
    else $error("side lines still driven");
  a_side_on: assert property (sw && reg_wr_data[6] |-> ##2 side_common_oe_n == 4'h0)
    else $error("side lines not driven");
  // ==========================================
  // Independence
  a_fast_keeps_side: assert property (fw |-> ##2 $stable(side_common_oe_n))
    else $error("fast write moved side");
  a_side_keeps_fast: assert property (sw |-> ##2 $stable(fast_standby))
    else $error("side write moved fast");
endmodule // crsw_route_monitor

bind crsw_route_select crsw_route_monitor crsw_route_monitor_i (.core_clk, .rstn, .reg_wr_en,
  .reg_addr, .reg_wr_data, .fast_out, .fast_standby, .side_common_lines, .side_common_oe_n);

/* File: verification/crsw_source_model.sv */
// Four sources feeding the switch.
// Assumes the bench supplies one word of line levels.
`timescale 1ns/100ps
module crsw_source_model
(
  // Levels
  input wire logic [31:0] lvl,
  // Lines
  output logic [15:0] fast_in,
  output logic [15:0] side_in
);
  assign fast_in = lvl[15:0];
  assign side_in = lvl[31:16];
endmodule // crsw_source_model

/* File: verification/crsw_route_select_test.sv */
// Random self-checking bench for the route decode.
// Assumes the design, checker and source model compile first.
`timescale 1ns/100ps
module crsw_route_select_test;
  logic core_clk, rstn, reg_wr_en, reg_rd_en, fast_standby;
  logic [7:0] reg_addr, reg_wr_data, reg_rd_data, fr, sr, d;
  logic [3:0] fast_out, side_common_lines, side_common_oe_n;
  logic [15:0] fast_in, side_in;
  logic [31:0] lvl, rnd;
  int mismatches = 0, tests_run = 0, cycles = 0;
  crsw_route_select crsw_route_select_i (.core_clk, .rstn, .reg_wr_en, .reg_rd_en,
    .reg_addr, .reg_wr_data, .reg_rd_data, .fast_in, .fast_out, .fast_standby,
    .side_in, .side_common_lines, .side_common_oe_n);
  crsw_source_model crsw_source_model_i (.lvl, .fast_in, .side_in);
  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  function automatic logic [31:0] lfsr(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // Mode code 11 is dropped, so the old mode survives.
  function automatic logic [7:0] keep(logic [7:0] o, logic [7:0] n);
    return {1'b0, n[6], (n[5:4] == 2'h3) ? o[5:4] : n[5:4], n[3:0]};
  endfunction
  function automatic logic [3:0] route(logic [7:0] c, logic [15:0] v, bit side);
    logic [3:0] p;
    p = c[3:0];
    if (!c[6]) return 4'h0;
    if (c[5:4] == 2'h0) return v[p[1:0] * 4 +: 4];
    if (c[5:4] == 2'h2) return {4{v[p]}};
    if (side) return {{2{v[(2 + p[2]) * 4 + p[1:0]]}}, {2{v[p[2] * 4 + p[1:0]]}}};
    return {{2{v[2 * p[2:0] + 1]}}, {2{v[2 * p[2:0]]}}};
  endfunction
  task automatic chk(logic [7:0] got, logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] v);
    @(negedge core_clk);
    reg_addr = a;
    reg_wr_data = v;
    reg_wr_en = 1'b1;
    @(negedge core_clk);
    reg_wr_en = 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] exp);
    @(negedge core_clk);
    reg_addr = a;
    reg_rd_en = 1'b1;
    @(negedge core_clk);
    reg_rd_en = 1'b0;
    @(negedge core_clk);
    chk(reg_rd_data, exp);
  endtask
  task automatic final_report;
    $display("compares %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      mismatches++;
      final_report;
    end
  end
  initial
  begin
    {rstn, reg_wr_en, reg_rd_en, reg_addr, reg_wr_data} = '0;
    rnd = 32'hbea0;
    lvl = 32'h0;
    repeat (12) @(negedge core_clk);
    rstn = 1'b1;
    repeat (3) @(negedge core_clk);
    fr = 8'h40;
    sr = 8'h40;
    wr(8'h05, 8'h00);
    rd(8'h00, fr);
    rd(8'h07, 8'h00);
    for (int i = 0; i < 48; i++)
    begin
      rnd = lfsr(lfsr(rnd));
      lvl = rnd;
      d = {rnd[7], 1'(i % 5 != 0), i[1:0], rnd[11:8]};
      wr(8'h00, d);
      fr = keep(fr, d);
      d = {rnd[15], 1'(i % 7 != 0), i[3:2], rnd[19:16]};
      wr(8'h01, d);
      sr = keep(sr, d);
      repeat (8) @(negedge core_clk);
      rd(8'h00, fr);
      rd(8'h01, sr);
      chk({3'h0, fast_standby, fast_out}, {3'h0, !fr[6], route(fr, lvl[15:0], 0)});
      chk({side_common_oe_n, side_common_lines}, {{4{!sr[6]}}, route(sr, lvl[31:16], 1)});
      $display("test %0d done", i);
    end
    // A reset in mid-run must bring both registers and routes back to their reset state.
    rstn = 1'b0;
    repeat (4) @(negedge core_clk);
    rstn = 1'b1;
    repeat (3) @(negedge core_clk);
    rd(8'h00, 8'h40);
    rd(8'h01, 8'h40);
    chk({3'h0, fast_standby, fast_out}, {3'h0, 1'b0, route(8'h40, lvl[15:0], 0)});
    chk({side_common_oe_n, side_common_lines}, {4'h0, route(8'h40, lvl[31:16], 1)});
    $display("reset test done");
    final_report;
  end
endmodule // crsw_route_select_test
